// *** include/pin_ctrl_pkg.sv ***
// Package: register map, field layout and reset values of the pin control bank
package pin_ctrl_pkg;
  // ==========================================================================
  // Register map (byte addresses; all offsets are ours)
  localparam logic [3:0] PULLUP_OFFS   = 4'h0;
  localparam logic [3:0] SLEW_OFFS     = 4'h4;
  localparam logic [3:0] DRIVE_OFFS    = 4'h8;
  localparam logic [3:0] DIR_OFFS      = 4'hc;
  localparam logic [3:0] PAD_STAT_OFFS = 4'h0 + 4'h0;
  // ==========================================================================
  // Widths and reset values
  localparam int         PORT_W        = 8;
  localparam int         DRIVE_W       = 7;
  localparam logic [7:0] PULLUP_RST    = 8'h00;
  localparam logic [7:0] SLEW_RST      = 8'h00;
  localparam logic [6:0] DRIVE_RST     = 7'h00;
  localparam logic [7:0] DIR_RST       = 8'h00;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // Pad controls handed to the pad ring
  typedef struct packed {
    logic [7:0] pullup_on;
    logic [7:0] slew_on;
  } first_pad_t;

  typedef struct packed {
    logic [6:0] high_drive;
  } second_pad_t;
endpackage

// *** logic/pad_gate.sv ***
// Per-pin gating of pad settings by pin direction
`timescale 1ns/10ps
module pad_gate (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           pullup_bits,
  input  wire logic [7:0]           slew_bits,
  input  wire logic [7:0]           dir_out,
  output pin_ctrl_pkg::first_pad_t  pad_q
);
  logic [7:0] pull_d;
  logic [7:0] slew_d;

  // ==========================================================================
  // Direction gating
  genvar g;
  generate
    for (g = 0; g < pin_ctrl_pkg::PORT_W; g++) begin : g_pin
      // Outputs never pull up; inputs never slew-limit
      assign pull_d[g] = pullup_bits[g] & ~dir_out[g];
      assign slew_d[g] = slew_bits[g] & dir_out[g];
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_q <= '0;
    end else begin
      pad_q <= '{pullup_on: pull_d, slew_on: slew_d};
    end
  end

  a_pull_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 pad_q.pullup_on == ($past(pullup_bits) & ~$past(dir_out)))
    else $error("pullup gating wrong");
  a_slew_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 pad_q.slew_on == ($past(slew_bits) & $past(dir_out)))
    else $error("slew gating wrong");
endmodule // pad_gate

// *** logic/port_pin_control_bank.sv ***
// AXI4-Lite register bank for first and second port pad controls
`timescale 1ns/10ps
module port_pin_control_bank (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic [3:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [3:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output pin_ctrl_pkg::first_pad_t   first_port_pins,
  output pin_ctrl_pkg::second_pad_t  second_port_pins
);
  // ==========================================================================
  // Registers
  logic [7:0] first_port_pullup_bits_q;
  logic [7:0] first_port_slew_bits_q;
  logic [6:0] second_port_drive_bits_q;
  logic [7:0] first_port_dir_q;
  logic [6:0] drive_out_q;
  logic [3:0] aw_addr_q;
  logic       aw_have_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        w_have_q;

  // ==========================================================================
  // Write channel: address and data accepted in either order
  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_have_q & w_have_q & ~s_axi_bvalid;

  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;

  function automatic logic hit(input logic [3:0] a);
    hit = (a == pin_ctrl_pkg::PULLUP_OFFS) || (a == pin_ctrl_pkg::SLEW_OFFS) ||
          (a == pin_ctrl_pkg::DRIVE_OFFS) || (a == pin_ctrl_pkg::DIR_OFFS);
  endfunction

  wire       wr_lane0 = do_write & w_strb_q[0];
  wire       wr_pull  = wr_lane0 & (aw_addr_q == pin_ctrl_pkg::PULLUP_OFFS);
  wire       wr_slew  = wr_lane0 & (aw_addr_q == pin_ctrl_pkg::SLEW_OFFS);
  wire       wr_drv   = wr_lane0 & (aw_addr_q == pin_ctrl_pkg::DRIVE_OFFS);
  wire       wr_dir   = wr_lane0 & (aw_addr_q == pin_ctrl_pkg::DIR_OFFS);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_have_q  <= 1'b0;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[3:2], 2'b00};
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pin_ctrl_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= hit(aw_addr_q) ? pin_ctrl_pkg::RESP_OKAY : pin_ctrl_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Control registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_port_pullup_bits_q <= pin_ctrl_pkg::PULLUP_RST;
      first_port_slew_bits_q   <= pin_ctrl_pkg::SLEW_RST;
      second_port_drive_bits_q <= pin_ctrl_pkg::DRIVE_RST;
      first_port_dir_q         <= pin_ctrl_pkg::DIR_RST;
    end else begin
      if (wr_pull) first_port_pullup_bits_q <= w_data_q[7:0];
      if (wr_slew) first_port_slew_bits_q <= w_data_q[7:0];
      // Bit 7 has no storage, so it can never read back as one
      if (wr_drv) second_port_drive_bits_q <= w_data_q[6:0];
      if (wr_dir) first_port_dir_q <= w_data_q[7:0];
    end
  end

  // ==========================================================================
  // Pad outputs
  pad_gate u_gate (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .pullup_bits (first_port_pullup_bits_q),
    .slew_bits   (first_port_slew_bits_q),
    .dir_out     (first_port_dir_q),
    .pad_q       (first_port_pins)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_out_q <= pin_ctrl_pkg::DRIVE_RST;
    end else begin
      drive_out_q <= second_port_drive_bits_q;
    end
  end
  assign second_port_pins.high_drive = drive_out_q;

  // ==========================================================================
  // Read channel: one cycle from address to data
  wire [7:0] rd_mux =
    (s_axi_araddr[3:2] == pin_ctrl_pkg::PULLUP_OFFS[3:2]) ? first_port_pullup_bits_q :
    (s_axi_araddr[3:2] == pin_ctrl_pkg::SLEW_OFFS[3:2])   ? first_port_slew_bits_q :
    (s_axi_araddr[3:2] == pin_ctrl_pkg::DRIVE_OFFS[3:2])  ? {1'b0, second_port_drive_bits_q} :
    first_port_dir_q;

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= pin_ctrl_pkg::RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h0, rd_mux};
      s_axi_rresp  <= pin_ctrl_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  // Reset values, seen at the first edge after release; drive bit 7 always reads as zero
  a_slew_reset: assert property (@(posedge sys_clk)
    $rose(rst_n) |-> first_port_slew_bits_q == 8'h00)
    else $error("slew bits not zero after reset");
  a_drive_reset: assert property (@(posedge sys_clk)
    $rose(rst_n) |-> second_port_drive_bits_q == 7'h00 && second_port_pins.high_drive == 7'h00)
    else $error("drive bits not zero after reset");
  a_drive_top_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_axi_rvalid && $past(s_axi_araddr[3:2] == 2'h2 && s_axi_arvalid && s_axi_arready)
    |-> s_axi_rdata[7] == 1'b0)
    else $error("drive bit 7 read as one");

  // Writes land in the register, then one edge later on the pads
  a_drive_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_drv |=> ##1 second_port_pins.high_drive == $past(w_data_q[6:0], 2))
    else $error("drive output not updated");
  a_pull_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_pull |=> first_port_pullup_bits_q == $past(w_data_q[7:0]))
    else $error("pullup write lost");
  a_slew_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_slew && w_data_q[0] && first_port_dir_q[0] && !wr_dir
    |=> ##1 first_port_pins.slew_on[0])
    else $error("slew not enabled");

  // Gating lags the direction by one edge, so checks judge a steady direction or wait that edge after a direction write
  a_out_no_pull: assert property (@(posedge sys_clk) disable iff (!rst_n)
    first_port_dir_q[0] && $stable(first_port_dir_q) |=> !first_port_pins.pullup_on[0])
    else $error("pullup on output pin");
  a_in_no_slew: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !first_port_dir_q[1] && $stable(first_port_dir_q) |=> !first_port_pins.slew_on[1])
    else $error("slew on input pin");
  a_dir_steers: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_dir |=> ##1 first_port_pins.pullup_on == ($past(first_port_pullup_bits_q) & ~first_port_dir_q))
    else $error("direction not applied");

  // Bus answers
  a_bresp_timing: assert property (@(posedge sys_clk) disable iff (!rst_n)
    do_write |=> s_axi_bvalid)
    else $error("no write response");
  a_bvalid_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  a_write_single: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_axi_bvalid |-> !aw_have_q && !w_have_q)
    else $error("new write taken during response");
  a_read_answer: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rresp == pin_ctrl_pkg::RESP_OKAY)
    else $error("no read response");
  a_rdata_upper: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read data not zero");

  c_write_drive: cover property (@(posedge sys_clk) disable iff (!rst_n) wr_drv);
  c_read_back: cover property (@(posedge sys_clk) disable iff (!rst_n) s_axi_rvalid && s_axi_rready);
  c_pull_on: cover property (@(posedge sys_clk) disable iff (!rst_n) |first_port_pins.pullup_on);
  c_dir_write: cover property (@(posedge sys_clk) disable iff (!rst_n) wr_dir);
  c_slew_on: cover property (@(posedge sys_clk) disable iff (!rst_n) |first_port_pins.slew_on);
endmodule // port_pin_control_bank

// *** sim/port_pin_control_bank_tb.sv ***
// Self-checking testbench of the pin control bank over AXI4-Lite
`timescale 1ns/10ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module port_pin_control_bank_tb;
  logic                        sys_clk = 1'b0;
  logic                        rst_n = 1'b0;
  logic [3:0]                  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic                        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0]                 s_axi_wdata = 32'h0, s_axi_rdata;
  logic                        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]                  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0]                 rd;
  pin_ctrl_pkg::first_pad_t    first_port_pins;
  pin_ctrl_pkg::second_pad_t   second_port_pins;
  int                          n_errors = 0;
  int                          n_tests = 0;

  always #20 sys_clk = ~sys_clk;

  port_pin_control_bank uut (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .first_port_pins(first_port_pins), .second_port_pins(second_port_pins));

  // ==========================================================================
  // Bus tasks: values read right after an edge are the ones sampled at it
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) begin aw_ok = 1'b1; s_axi_awvalid <= 1'b0; end
      if (s_axi_wvalid && s_axi_wready) begin w_ok = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge sys_clk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // One idle edge keeps the next call from reassigning a strobe in this time step
    @(posedge sys_clk);
  endtask

  task automatic axr(input logic [3:0] a);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Pads follow a taken write within a fixed few edges
  task automatic settle();
    repeat (3) @(posedge sys_clk);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    axr(pin_ctrl_pkg::SLEW_OFFS);  `CHK(rd, 32'h0)
    axr(pin_ctrl_pkg::DRIVE_OFFS); `CHK(rd, 32'h0)
    axr(pin_ctrl_pkg::PULLUP_OFFS); `CHK(rd, 32'h0)
    `CHK(first_port_pins, 16'h0000)
    `CHK(second_port_pins, 7'h00)
  endtask

  task automatic t_first();
    axw(pin_ctrl_pkg::PULLUP_OFFS, 32'h0000_00a5, 4'hf);
    axw(pin_ctrl_pkg::SLEW_OFFS, 32'h0000_003c, 4'hf);
    settle();
    `CHK(first_port_pins.pullup_on, 8'ha5)
    `CHK(first_port_pins.slew_on, 8'h00)
    // Half the pins become outputs: pullups drop there, slew limiting appears
    axw(pin_ctrl_pkg::DIR_OFFS, 32'h0000_000f, 4'hf);
    settle();
    `CHK(first_port_pins.pullup_on, 8'ha0)
    `CHK(first_port_pins.slew_on, 8'h0c)
    axw(pin_ctrl_pkg::DIR_OFFS, 32'h0000_00ff, 4'hf);
    settle();
    `CHK(first_port_pins, 16'h003c)
    axr(pin_ctrl_pkg::PULLUP_OFFS); `CHK(rd, 32'h0000_00a5)
    axw(pin_ctrl_pkg::DIR_OFFS, 32'h0, 4'hf);
    axw(pin_ctrl_pkg::PULLUP_OFFS, 32'h0000_005a, 4'hf);
    settle();
    `CHK(first_port_pins.pullup_on, 8'h5a)
  endtask

  task automatic t_drive();
    axw(pin_ctrl_pkg::DRIVE_OFFS, 32'hffff_ffff, 4'hf);
    `CHK(resp, pin_ctrl_pkg::RESP_OKAY)
    axr(pin_ctrl_pkg::DRIVE_OFFS); `CHK(rd, 32'h0000_007f)
    settle();
    `CHK(second_port_pins.high_drive, 7'h7f)
    // A write without the low byte lane must leave the register alone
    axw(pin_ctrl_pkg::DRIVE_OFFS, 32'h0000_0012, 4'he);
    axr(pin_ctrl_pkg::DRIVE_OFFS); `CHK(rd, 32'h0000_007f)
    axw(pin_ctrl_pkg::DRIVE_OFFS, 32'h0000_002a, 4'hf);
    settle();
    `CHK(second_port_pins.high_drive, 7'h2a)
  endtask

  // An unaligned read lands on the word that holds it
  task automatic t_odd();
    axr(4'h2); `CHK(resp, pin_ctrl_pkg::RESP_OKAY)
    `CHK(rd, 32'h0000_005a)
  endtask

  // A reset in mid-run must clear what earlier scenarios wrote
  task automatic t_rereset();
    rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    axr(pin_ctrl_pkg::SLEW_OFFS);  `CHK(rd, 32'h0)
    axr(pin_ctrl_pkg::DRIVE_OFFS); `CHK(rd, 32'h0)
    `CHK(first_port_pins, 16'h0000)
    `CHK(second_port_pins.high_drive, 7'h00)
  endtask

  // ==========================================================================
  // Verdict
  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_first();
    t_drive();
    t_odd();
    t_rereset();
    summarize();
  end

  // The whole run needs about a hundred cycles
  initial begin
    #100us;
    n_errors++;
    summarize();
  end
endmodule  // port_pin_control_bank_tb
